//--- rtl/dopd_defines.svh
// Constants for the digital output pattern driver.
// Assumes a 200 MHz system clock.
`ifndef DOPD_DEFINES_SVH
`define DOPD_DEFINES_SVH
`define DOPD_CLK_MHZ 200
`define DOPD_STEP_US 200
`define DOPD_STEP_CYCLES (`DOPD_STEP_US * `DOPD_CLK_MHZ)
`define DOPD_BUF_DEPTH 32
`define DOPD_NIB_W 4
`define DOPD_OUT_W 8
`define DOPD_OUT_RESET 8'h00
`define DOPD_CNT_W 16
`endif

//--- rtl/dopd_pkg.sv
// Types for the digital output pattern driver.
// Used by the driver and its buffer store.
package dopd_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_DIRECT, ST_BUFFER} dopd_mode_t;
endpackage : dopd_pkg

//--- rtl/dopd_if.sv
// Carrier between driver and its pattern store.
// Single clock domain.
`timescale 1ns/1ps
interface dopd_if;
	logic wr_en;
	logic [4:0] wr_addr;
	logic [3:0] wr_data;
	logic [4:0] rd_addr;
	logic [3:0] rd_data;
	modport ctrl(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : dopd_if

//--- rtl/dopd_store.sv
// Circular pattern buffer storage, 32 nibbles.
// Written by the driver on the clock; read asynchronously by address.
`timescale 1ns/1ps
`include "dopd_defines.svh"
module dopd_store
	import dopd_pkg::*;
(
	input wire logic clk_in,
	input wire logic clk_en_in,
	dopd_if.store bus
);
	logic [`DOPD_NIB_W-1:0] mem_q [0:`DOPD_BUF_DEPTH-1];
	always_ff @(posedge clk_in)
	begin
		if (clk_en_in && bus.wr_en)
		begin
			mem_q[bus.wr_addr] <= bus.wr_data;
		end
	end
	assign bus.rd_data = mem_q[bus.rd_addr];
endmodule : dopd_store

//--- rtl/dopd_driver.sv
// Digital output pattern driver: direct writes and buffered nibble playback.
// Assumes command interpreter and timebase on clk_in; tick is one-cycle pulse.
`timescale 1ns/1ps
`include "dopd_defines.svh"
module dopd_driver
	import dopd_pkg::*;
#(
	parameter int STEP_CYCLES = `DOPD_STEP_CYCLES
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic direct_valid_in,
	input wire logic [7:0] direct_data_in,
	output logic direct_ready_out,
	input wire logic load_start_in,
	input wire logic [5:0] load_count_in,
	input wire logic load_valid_in,
	input wire logic [3:0] load_data_in,
	input wire logic run_start_in,
	input wire logic [15:0] run_samples_in,
	input wire logic sample_tick_in,
	output logic [7:0] lines_out,
	output logic running_out
);
	dopd_if sif();
	dopd_store u_store (
		.clk_in(clk_in),
		.clk_en_in(clk_en_in),
		.bus(sif.store)
	);

	dopd_mode_t mode_q, mode_d;
	logic [7:0] lines_q, lines_d;
	logic [31:0] gap_q, gap_d;
	logic [5:0] count_q, count_d;
	logic [5:0] wptr_q, wptr_d;
	logic [4:0] rnext;
	logic [4:0] rptr_q, rptr_d;
	logic [15:0] left_q, left_d;
	logic first_q, first_d;

	function automatic logic [4:0] wrap_inc(input logic [4:0] p, input logic [5:0] n);
		if ({1'b0, p} + 6'h01 >= n)
		begin
			return 5'h00;
		end
		return p + 5'h01;
	endfunction : wrap_inc

	assign direct_ready_out = (gap_q == 32'h0000_0000) && (mode_q != ST_BUFFER);
	assign sif.wr_en = load_valid_in && (wptr_q < count_q);
	assign sif.wr_addr = wptr_q[4:0];
	assign sif.wr_data = load_data_in;
	assign rnext = first_q ? 5'h00 : wrap_inc(rptr_q, count_q);
	assign sif.rd_addr = rnext;
	assign lines_out = lines_q;
	assign running_out = (mode_q == ST_BUFFER);

	always_comb
	begin
		mode_d = mode_q;
		lines_d = lines_q;
		gap_d = gap_q;
		count_d = count_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		left_d = left_q;
		first_d = first_q;
		if (gap_q != 32'h0000_0000)
		begin
			gap_d = gap_q - 32'h0000_0001;
		end
		if (load_start_in)
		begin
			count_d = (load_count_in > 6'h20) ? 6'h20 : load_count_in;
			wptr_d = 6'h00;
		end
		else if (sif.wr_en)
		begin
			wptr_d = wptr_q + 6'h01;
		end
		case (mode_q)
			ST_IDLE, ST_DIRECT:
			begin
				if (direct_valid_in && direct_ready_out)
				begin
					lines_d = direct_data_in;
					gap_d = STEP_CYCLES[31:0] - 32'h0000_0001;
					mode_d = ST_DIRECT;
				end
				else if (run_start_in && count_q != 6'h00 && run_samples_in != 16'h0000)
				begin
					mode_d = ST_BUFFER;
					left_d = run_samples_in;
					rptr_d = 5'h00;
					first_d = 1'b1;
				end
			end
			ST_BUFFER:
			begin
				if (sample_tick_in)
				begin
					rptr_d = rnext;
					first_d = 1'b0;
					lines_d = {lines_q[7:4], sif.rd_data};
					left_d = left_q - 16'h0001;
					if (left_q == 16'h0001)
					begin
						mode_d = ST_IDLE;
					end
				end
			end
			default:
			begin
				mode_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			mode_q <= ST_IDLE;
			lines_q <= `DOPD_OUT_RESET;
			gap_q <= 32'h0000_0000;
			count_q <= 6'h00;
			wptr_q <= 6'h00;
			rptr_q <= 5'h00;
			left_q <= 16'h0000;
			first_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			mode_q <= mode_d;
			lines_q <= lines_d;
			gap_q <= gap_d;
			count_q <= count_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			left_q <= left_d;
			first_q <= first_d;
		end
	end

	direct_out_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && direct_valid_in && direct_ready_out && mode_q != ST_BUFFER
		|=> lines_out == $past(direct_data_in))
		else $error("direct value not driven");
	direct_gap_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && direct_valid_in && direct_ready_out && mode_q != ST_BUFFER
		|=> !direct_ready_out)
		else $error("direct spacing violated");
	upper_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		mode_q == ST_BUFFER
		|=> lines_out[7:4] == $past(lines_out[7:4]))
		else $error("buffer touched upper lines");
	ptr_range_a: assert property (@(posedge clk_in) disable iff (reset_in)
		mode_q == ST_BUFFER
		|-> {1'b0, rptr_q} < count_q)
		else $error("pointer past count");
	count_max_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && load_start_in
		|=> count_q <= 6'h20 && count_q <= $past(load_count_in))
		else $error("entry count not clamped");
	run_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && !running_out && run_start_in && !(direct_valid_in && direct_ready_out)
		&& count_q != 6'h00 && run_samples_in != 16'h0000
		|=> running_out && left_q == $past(run_samples_in))
		else $error("run not started");
	run_end_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && mode_q == ST_BUFFER && sample_tick_in && left_q == 16'h0001
		|=> mode_q == ST_IDLE)
		else $error("run did not end");
	pattern_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		mode_q == ST_BUFFER && !sample_tick_in
		|=> $stable(lines_out))
		else $error("pattern changed without tick");
	freeze_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		!clk_en_in
		|=> $stable(lines_out) && $stable(mode_q) && $stable(gap_q))
		else $error("state moved while disabled");
	reset_state_a: assert property (@(posedge clk_in)
		reset_in
		|=> lines_out == `DOPD_OUT_RESET && !running_out && direct_ready_out)
		else $error("reset state wrong");
	tick_adv_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && mode_q == ST_BUFFER && sample_tick_in
		|=> rptr_q == ($past(first_q) ? 5'h00
		: ($past(rptr_q) == $past(count_q[4:0]) - 5'h01) ? 5'h00 : $past(rptr_q) + 5'h01))
		else $error("tick did not advance");
	tick_data_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && mode_q == ST_BUFFER && sample_tick_in && !sif.wr_en
		|=> lines_out[3:0] == u_store.mem_q[rptr_q])
		else $error("entry not driven");
	load_ptr_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && load_start_in
		|=> wptr_q == 6'h00)
		else $error("load not restarted");
endmodule : dopd_driver

//--- bench/dopd_load_model.sv
// Model of the loads on the output lines.
// Samples the lines on the system clock.
`timescale 1ns/1ps
module dopd_load_model
(
	input wire logic clk_in,
	input wire logic [7:0] lines_in,
	output logic [7:0] seen_out
);
	always_ff @(posedge clk_in)
		seen_out <= lines_in;
endmodule : dopd_load_model

//--- bench/digital_output_pattern_driver_test.sv
// Bench for the pattern driver: direct writes, buffered playback.
// Loads seen through the load model; spacing shortened to 8 cycles.
`timescale 1ns/1ps
module digital_output_pattern_driver_test
	import dopd_pkg::*;
;
	localparam int STEP = 8;
	logic clk_in, reset_in, en, dv, ld_start, ld_valid, run_start, tick, ready, running;
	logic [7:0] dd, lines, seen;
	logic [5:0] ld_count;
	logic [3:0] ld_data;
	logic [15:0] samples;
	int bad_count, total_checks;
	dopd_driver #(.STEP_CYCLES(STEP)) i_dopd_driver (.clk_in(clk_in), .reset_in(reset_in),
		.clk_en_in(en), .direct_valid_in(dv), .direct_data_in(dd),
		.direct_ready_out(ready), .load_start_in(ld_start), .load_count_in(ld_count),
		.load_valid_in(ld_valid), .load_data_in(ld_data), .run_start_in(run_start),
		.run_samples_in(samples), .sample_tick_in(tick), .lines_out(lines),
		.running_out(running));
	dopd_load_model i_dopd_load_model (.clk_in(clk_in), .lines_in(lines), .seen_out(seen));
	initial
	begin
		clk_in = 0;
		forever #2.5 clk_in = ~clk_in;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task direct_case;
		int i;
		dv = 1;
		dd = 8'h07;
		cyc(1);
		dv = 0;
		cyc(3);
		chk("lines", seen, 8'h07);
		dv = 1;
		dd = 8'hA0;
		cyc(3);
		chk("ready", ready, 0);
		chk("lines", seen, 8'h07);
		i = 0;
		while (lines !== 8'hA0 && i < 12)
		begin
			cyc(1);
			i++;
		end
		dv = 0;
		chk("taken", lines, 8'hA0);
		chk("spacing", 16'(i), 16'(STEP - 6));
	endtask : direct_case
	task buffer_case;
		ld_count = 5;
		ld_start = 1;
		cyc(1);
		ld_start = 0;
		ld_valid = 1;
		for (int i = 0; i < 5; i++)
		begin
			ld_data = 4'(i + 1);
			cyc(1);
		end
		ld_valid = 0;
		samples = 7;
		run_start = 1;
		cyc(1);
		run_start = 0;
		cyc(1);
		chk("running", running, 1);
		chk("busy", ready, 0);
		for (int i = 0; i < 8; i++)
		begin
			tick = 1;
			cyc(1);
			tick = 0;
			cyc(3);
			chk("lines", seen, {4'hA, 4'((i > 6 ? 6 : i) % 5 + 1)});
		end
		chk("running", running, 0);
	endtask : buffer_case
	task freeze_case;
		en = 0;
		dv = 1;
		dd = 8'h5C;
		cyc(3);
		chk("frozen", lines, 8'hA2);
		en = 1;
		cyc(1);
		dv = 0;
		chk("thawed", lines, 8'h5C);
		chk("ready", ready, 0);
	endtask : freeze_case
	task deep_case;
		ld_count = 6'h21;
		ld_start = 1;
		cyc(1);
		ld_start = 0;
		ld_valid = 1;
		for (int i = 0; i < 33; i++)
		begin
			ld_data = (i == 32) ? 4'hF : 4'(i % 15);
			cyc(1);
		end
		ld_valid = 0;
		samples = 16'h0021;
		run_start = 1;
		cyc(1);
		run_start = 0;
		for (int i = 0; i < 33; i++)
		begin
			tick = 1;
			cyc(1);
			tick = 0;
			chk("entry", lines, {4'h5, 4'((i % 32) % 15)});
			cyc(1);
		end
		chk("ended", running, 0);
	endtask : deep_case
	task reset_case;
		samples = 16'h0064;
		run_start = 1;
		cyc(1);
		run_start = 0;
		tick = 1;
		cyc(1);
		tick = 0;
		chk("running", running, 1);
		chk("entry", lines, 8'h50);
		reset_in = 1;
		cyc(1);
		reset_in = 0;
		chk("reset", {ready, running, lines}, 10'h200);
		run_start = 1;
		cyc(1);
		run_start = 0;
		cyc(1);
		chk("refused", running, 0);
		chk("loads", seen, 8'h00);
	endtask : reset_case
	initial
	begin
		{dv, ld_start, ld_valid, run_start, tick, dd, ld_count, ld_data, samples} = 0;
		en = 1;
		reset_in = 1;
		cyc(5);
		reset_in = 0;
		cyc(2);
		chk("reset", {ready, seen}, 9'h100);
		direct_case();
		buffer_case();
		freeze_case();
		deep_case();
		reset_case();
		summarize();
	end
	initial
	begin
		#20000;
		bad_count++;
		summarize();
	end
endmodule : digital_output_pattern_driver_test
